// ===== common/mmpu_pkg.sv
// Constants, field layout and state of the multi-match pulse unit.
// Assumes one clock, one active-low asynchronous reset.
//
// Functional notes
// - A 32-bit counter advances once per wrap of a programmable 32-bit prescaler.
// - The count is compared with each match value and a hit may raise an interrupt.
// - Seven match values serve up to six single-edge or three double-edge outputs, or a mix.
// - In pulse mode, a hit on the cycle match register resets the counter and sets the shared period.
// - Single-edge outputs rise on the cycle match unless held constantly low.
// - A single-edge output falls at the hit of its own match value.
// - A double-edge output rises and falls at two dedicated match values.
// - Either edge may lie anywhere in the cycle, giving positive or negative pulses.
// - Period and width are any whole number of counter ticks, one rate for all.
// - Per match value: continue, stop or reset the counter, each with optional interrupt.
// - In pulse mode, new match values take effect only after software releases them, without glitches.
// - With pulse mode off the unit is a plain timer and drives no pulse outputs.
`default_nettype none

package mmpu_pkg;

  localparam int NUM_MATCH = 7;
  localparam int NUM_OUT = 6;

  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_CTRL = 8'h04;
  localparam logic [7:0] OFS_COUNT = 8'h08;
  localparam logic [7:0] OFS_PRESCALE = 8'h0c;
  localparam logic [7:0] OFS_PRECOUNT = 8'h10;
  localparam logic [7:0] OFS_ACTION = 8'h14;
  localparam logic [7:0] OFS_MATCH0 = 8'h18;
  localparam logic [7:0] OFS_OUTCFG = 8'h34;
  localparam logic [7:0] OFS_RELEASE = 8'h38;
  localparam logic [7:0] OFS_MASK = 8'h3c;

  // Control bits
  localparam int CTRL_EN = 0;
  localparam int CTRL_RST = 1;
  localparam int CTRL_PWM = 3;

  // Action field: three bits per match value
  localparam int ACT_INT = 0;
  localparam int ACT_RST = 1;
  localparam int ACT_STOP = 2;

  // Output config: double-edge select in [6:2], enables in [14:9]
  localparam int OCFG_DBL = 2;
  localparam int OCFG_EN = 9;

  localparam logic [31:0] RST_WORD = 32'h0000_0000;

  typedef struct packed {
    logic [31:0] tc;
    logic [31:0] pc;
    logic [31:0] pr;
    logic cnt_en;
    logic cnt_rst;
    logic pwm_en;
    logic [20:0] act;
    logic [6:0][31:0] mr_sh;
    logic [6:0][31:0] mr_act;
    logic [4:0] dbl;
    logic [5:0] out_en;
    logic [6:0] rel;
    logic [6:0] ist;
    logic [6:0] imask;
    logic [5:0] pwm;
    logic [31:0] rdata;
  } mmpu_state_t;

endpackage : mmpu_pkg

`default_nettype wire

// ===== logic/mmpu_top.sv
// Multi-match pulse unit: prescaled timer, seven match values, six pulse outputs.
// Assumes a register master that follows the one-cycle strobe protocol.
//
// The plain strobed port and the address map were chosen for this implementation.
`default_nettype none

module mmpu_top (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic we_i,
  input wire logic re_i,
  output logic [31:0] rdata_o,
  output logic irq_o,
  output logic [5:0] pwm_o,
  output logic [5:0] pwm_oe_o
);

  ////////////////////////////////////////////////////////////////////////////

  function automatic logic act_bit(input logic [20:0] act, input int idx, input int pos);
    act_bit = act[3 * idx + pos];
  endfunction : act_bit

  function automatic logic [7:0] mr_ofs(input int idx);
    mr_ofs = mmpu_pkg::OFS_MATCH0 + 8'(4 * idx);
  endfunction : mr_ofs

  ////////////////////////////////////////////////////////////////////////////

  mmpu_pkg::mmpu_state_t s_r;
  mmpu_pkg::mmpu_state_t s_nxt;
  logic tick;
  logic [6:0] m;
  logic [6:0] evt;
  logic rst_any;
  logic stop_any;
  logic set_c;
  logic clr_c;

  always_comb begin
    s_nxt = s_r;
    s_nxt.rdata = mmpu_pkg::RST_WORD;
    set_c = 1'b0;
    clr_c = 1'b0;

    tick = s_r.cnt_en && !s_r.cnt_rst && (s_r.pc == s_r.pr);
    for (int i = 0; i < mmpu_pkg::NUM_MATCH; i++) begin
      m[i] = tick && (s_r.tc == s_r.mr_act[i]);
    end

    // Cycle match always restarts the period in pulse mode
    rst_any = s_r.pwm_en && m[0];
    stop_any = 1'b0;
    for (int i = 0; i < mmpu_pkg::NUM_MATCH; i++) begin
      evt[i] = m[i] && act_bit(s_r.act, i, mmpu_pkg::ACT_INT);
      if (m[i] && act_bit(s_r.act, i, mmpu_pkg::ACT_RST)) begin
        rst_any = 1'b1;
      end
      if (m[i] && act_bit(s_r.act, i, mmpu_pkg::ACT_STOP)) begin
        stop_any = 1'b1;
      end
    end

    if (s_r.cnt_rst) begin
      s_nxt.tc = mmpu_pkg::RST_WORD;
      s_nxt.pc = mmpu_pkg::RST_WORD;
    end else if (s_r.cnt_en) begin
      if (tick) begin
        s_nxt.pc = mmpu_pkg::RST_WORD;
        s_nxt.tc = rst_any ? mmpu_pkg::RST_WORD : s_r.tc + 32'h0000_0001;
      end else begin
        s_nxt.pc = s_r.pc + 32'h0000_0001;
      end
    end
    if (stop_any) begin
      s_nxt.cnt_en = 1'b0;
    end

    // Output n (0-based) falls at match n+1; rises at cycle match or match n
    for (int n = 0; n < mmpu_pkg::NUM_OUT; n++) begin
      clr_c = m[n + 1];
      if (n >= 1 && s_r.dbl[n - 1]) begin
        set_c = m[n];
      end else begin
        set_c = m[0];
        // Zero fall value would otherwise leave a one-tick pulse
        clr_c = m[n + 1] || (m[0] && s_r.mr_act[n + 1] == mmpu_pkg::RST_WORD);
      end
      // Fall wins on a tie, so a zero fall value keeps a single-edge output low
      if (!s_r.pwm_en) begin
        s_nxt.pwm[n] = 1'b0;
      end else if (clr_c) begin
        s_nxt.pwm[n] = 1'b0;
      end else if (set_c) begin
        s_nxt.pwm[n] = 1'b1;
      end
    end

    // Released values load only at the period boundary
    if (s_r.pwm_en && m[0]) begin
      for (int i = 0; i < mmpu_pkg::NUM_MATCH; i++) begin
        if (s_r.rel[i]) begin
          s_nxt.mr_act[i] = s_r.mr_sh[i];
        end
      end
      s_nxt.rel = 7'h00;
    end

    // Hardware set wins over a same-cycle clear
    s_nxt.ist = s_r.ist | evt;
    if (we_i && addr_i == mmpu_pkg::OFS_STATUS) begin
      s_nxt.ist = (s_r.ist & ~wdata_i[6:0]) | evt;
    end

    if (we_i) begin
      case (addr_i)
        mmpu_pkg::OFS_CTRL: begin
          s_nxt.cnt_en = wdata_i[mmpu_pkg::CTRL_EN];
          s_nxt.cnt_rst = wdata_i[mmpu_pkg::CTRL_RST];
          s_nxt.pwm_en = wdata_i[mmpu_pkg::CTRL_PWM];
        end
        mmpu_pkg::OFS_COUNT: s_nxt.tc = wdata_i;
        mmpu_pkg::OFS_PRESCALE: s_nxt.pr = wdata_i;
        mmpu_pkg::OFS_PRECOUNT: s_nxt.pc = wdata_i;
        mmpu_pkg::OFS_ACTION: s_nxt.act = wdata_i[20:0];
        mmpu_pkg::OFS_OUTCFG: begin
          s_nxt.dbl = wdata_i[mmpu_pkg::OCFG_DBL +: 5];
          s_nxt.out_en = wdata_i[mmpu_pkg::OCFG_EN +: 6];
        end
        mmpu_pkg::OFS_RELEASE: s_nxt.rel = s_r.rel | wdata_i[6:0];
        mmpu_pkg::OFS_MASK: s_nxt.imask = wdata_i[6:0];
        default: begin
          for (int i = 0; i < mmpu_pkg::NUM_MATCH; i++) begin
            if (addr_i == mr_ofs(i)) begin
              s_nxt.mr_sh[i] = wdata_i;
              // Plain timer mode has no release step
              if (!s_r.pwm_en) begin
                s_nxt.mr_act[i] = wdata_i;
              end
            end
          end
        end
      endcase
    end

    if (re_i) begin
      case (addr_i)
        mmpu_pkg::OFS_STATUS: s_nxt.rdata = {25'h000_0000, s_r.ist};
        mmpu_pkg::OFS_CTRL: begin
          s_nxt.rdata[mmpu_pkg::CTRL_EN] = s_r.cnt_en;
          s_nxt.rdata[mmpu_pkg::CTRL_RST] = s_r.cnt_rst;
          s_nxt.rdata[mmpu_pkg::CTRL_PWM] = s_r.pwm_en;
        end
        mmpu_pkg::OFS_COUNT: s_nxt.rdata = s_r.tc;
        mmpu_pkg::OFS_PRESCALE: s_nxt.rdata = s_r.pr;
        mmpu_pkg::OFS_PRECOUNT: s_nxt.rdata = s_r.pc;
        mmpu_pkg::OFS_ACTION: s_nxt.rdata = {11'h000, s_r.act};
        mmpu_pkg::OFS_OUTCFG: begin
          s_nxt.rdata[mmpu_pkg::OCFG_DBL +: 5] = s_r.dbl;
          s_nxt.rdata[mmpu_pkg::OCFG_EN +: 6] = s_r.out_en;
        end
        mmpu_pkg::OFS_RELEASE: s_nxt.rdata = {25'h000_0000, s_r.rel};
        mmpu_pkg::OFS_MASK: s_nxt.rdata = {25'h000_0000, s_r.imask};
        default: begin
          for (int i = 0; i < mmpu_pkg::NUM_MATCH; i++) begin
            if (addr_i == mr_ofs(i)) begin
              s_nxt.rdata = s_r.mr_sh[i];
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign rdata_o = s_r.rdata;
  assign irq_o = |(s_r.ist & s_r.imask);
  assign pwm_o = s_r.pwm;
  assign pwm_oe_o = s_r.pwm_en ? s_r.out_en : 6'h00;

  ////////////////////////////////////////////////////////////////////////////

  chk_prescale_tick: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (s_r.cnt_en && !s_r.cnt_rst && !tick && !(we_i && addr_i == mmpu_pkg::OFS_PRECOUNT))
    |=> s_r.pc == $past(s_r.pc) + 32'h0000_0001)
    else $error("prescale count did not advance");

  chk_count_step: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (tick && !rst_any && !s_r.cnt_rst && !we_i)
    |=> s_r.tc == $past(s_r.tc) + 32'h0000_0001 && s_r.pc == 32'h0000_0000)
    else $error("counter did not step on prescale wrap");

  chk_cycle_reset: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (s_r.pwm_en && m[0] && !we_i) |=> s_r.tc == 32'h0000_0000)
    else $error("cycle match did not restart the counter");

  chk_single_rise: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (s_r.pwm_en && m[0] && !m[1] && s_r.mr_act[1] != mmpu_pkg::RST_WORD) |=> pwm_o[0])
    else $error("single-edge output did not rise at cycle start");

  chk_single_fall: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (s_r.pwm_en && m[1]) |=> !pwm_o[0] ##1 (!pwm_o[0] || $past(m[0])))
    else $error("single-edge output did not fall at its match");

  chk_double_edges: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (s_r.pwm_en && s_r.dbl[0] && m[1] && !m[2]) |=> pwm_o[1])
    else $error("double-edge output did not rise at its match");

  chk_match_stop: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (stop_any && !we_i) |=> !s_r.cnt_en ##1 $stable(s_r.tc))
    else $error("stop action did not halt the counter");

  chk_match_irq: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (evt[0] && s_r.imask[0]) |=> s_r.ist[0] && irq_o)
    else $error("match interrupt not raised");

  chk_hold_unreleased: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (s_r.pwm_en && !m[0]) |=> $stable(s_r.mr_act))
    else $error("active match set changed mid-cycle");

  chk_release_load: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (s_r.pwm_en && m[0] && s_r.rel[1]) |=> s_r.mr_act[1] == $past(s_r.mr_sh[1])
      && !s_r.rel[1] || $past(we_i))
    else $error("released value not loaded at cycle match");

  chk_timer_quiet: assert property (@(posedge clk_i) disable iff (!rstn_i)
    !s_r.pwm_en |-> pwm_oe_o == 6'h00 ##1 (pwm_o == 6'h00 || s_r.pwm_en))
    else $error("pulse outputs driven in timer mode");

  chk_const_low: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (s_r.pwm_en && m[0] && s_r.mr_act[1] == mmpu_pkg::RST_WORD) |=> !pwm_o[0])
    else $error("zero fall value did not keep output low");

  chk_double_fall: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (s_r.pwm_en && s_r.dbl[0] && m[2]) |=> !pwm_o[1])
    else $error("double-edge output did not fall at its match");

  chk_status_set: assert property (@(posedge clk_i) disable iff (!rstn_i)
    evt[1] |=> s_r.ist[1])
    else $error("match event not recorded in status");

  chk_status_sticky: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (s_r.ist[0] && !(we_i && addr_i == mmpu_pkg::OFS_STATUS)) |=> s_r.ist[0])
    else $error("status bit lost without a clear");

  chk_status_clear: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (we_i && addr_i == mmpu_pkg::OFS_STATUS && wdata_i[0] && !evt[0]) |=> !s_r.ist[0])
    else $error("status bit not cleared by write of one");

  chk_rst_action: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (m[2] && act_bit(s_r.act, 2, mmpu_pkg::ACT_RST) && !we_i) |=> s_r.tc == 32'h0000_0000)
    else $error("reset action did not clear the counter");

  chk_hold_reset: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (s_r.cnt_rst && !we_i) |=> s_r.tc == 32'h0000_0000 && s_r.pc == 32'h0000_0000)
    else $error("hold reset did not clear the counters");

  chk_idle_counter: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (!s_r.cnt_en && !s_r.cnt_rst && !we_i) |=> $stable(s_r.tc))
    else $error("disabled counter moved");

  chk_release_clear: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (s_r.pwm_en && m[0] && !(we_i && addr_i == mmpu_pkg::OFS_RELEASE)) |=> s_r.rel == 7'h00)
    else $error("release bits not cleared at load");

  chk_release_hold: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (s_r.rel[0] && !(s_r.pwm_en && m[0])) |=> s_r.rel[0])
    else $error("pending release dropped before cycle match");

  chk_direct_write: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (!s_r.pwm_en && we_i && addr_i == mmpu_pkg::OFS_MATCH0) |=> s_r.mr_act[0] == $past(wdata_i))
    else $error("timer-mode match write not applied at once");

endmodule : mmpu_top

`default_nettype wire

// ===== tb/mmpu_top_tb.sv
// Self-checking bench for the multi-match pulse unit.
// Assumes mmpu_pkg is compiled first; drives the register port directly.
`default_nettype none

module mmpu_top_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0000_0000;
  logic we_i = 1'b0;
  logic re_i = 1'b0;
  logic [31:0] rdata_o;
  logic irq_o;
  logic [5:0] pwm_o;
  logic [5:0] pwm_oe_o;
  logic rd_d = 1'b0;
  logic [31:0] exp_q[$];
  logic [31:0] seed = 32'h0000_f820;
  int n_fail = 0;
  int checks = 0;
  int cyc = 0;

  mmpu_top dut (.clk_i(clk_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .we_i(we_i), .re_i(re_i), .rdata_o(rdata_o), .irq_o(irq_o), .pwm_o(pwm_o),
    .pwm_oe_o(pwm_oe_o));

  always #12.5 clk_i = ~clk_i;

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic cmp_rd(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: read %h expected %h", $time, got, exp);
    end
  endtask : cmp_rd

  task automatic cmp_pin(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: pins %h expected %h", $time, got, exp);
    end
  endtask : cmp_pin

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : give_verdict

  ////////////////////////////////////////////////////////////////////////////
  // Bus tasks: at least one idle cycle between strobes keeps each strobe a clean pulse
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    we_i <= 1'b1;
    @(posedge clk_i);
    we_i <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    exp_q.push_back(exp);
    @(posedge clk_i);
    addr_i <= a;
    re_i <= 1'b1;
    @(posedge clk_i);
    re_i <= 1'b0;
    @(posedge clk_i);
  endtask : rd

  always @(posedge clk_i) rd_d <= re_i;

  // Read data stand only in the cycle after the strobe
  always @(negedge clk_i) begin
    if (rd_d) begin
      cmp_rd(rdata_o, exp_q.pop_front());
    end
  end

  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      n_fail++;
      give_verdict();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Timer-mode writes land in the active set at once, so set up with pulses off
  task automatic setup(input logic [31:0] pr, m0, m1, m2, ocfg);
    wr(mmpu_pkg::OFS_CTRL, 32'h0000_0000);
    wr(mmpu_pkg::OFS_PRESCALE, pr);
    wr(mmpu_pkg::OFS_MATCH0, m0);
    wr(mmpu_pkg::OFS_MATCH0 + 8'h04, m1);
    wr(mmpu_pkg::OFS_MATCH0 + 8'h08, m2);
    wr(mmpu_pkg::OFS_OUTCFG, ocfg);
    wr(mmpu_pkg::OFS_COUNT, 32'h0000_0000);
    wr(mmpu_pkg::OFS_PRECOUNT, 32'h0000_0000);
    wr(mmpu_pkg::OFS_CTRL, 32'h0000_0009);
    repeat (10) @(posedge clk_i);
  endtask : setup

  // High cycles of one channel over a whole number of periods
  task automatic count_hi(input int ch, input int n, input int exp);
    int hi;
    hi = 0;
    repeat (n) begin
      @(negedge clk_i);
      hi += int'(pwm_o[ch]);
    end
    cmp_pin(32'(hi), 32'(exp));
  endtask : count_hi

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] v;
    repeat (10) @(posedge clk_i);
    rstn_i <= 1'b1;
    @(negedge clk_i);
    cmp_pin(32'({irq_o, pwm_o, pwm_oe_o}), 32'h0000_0000);
    rd(mmpu_pkg::OFS_CTRL, 32'h0000_0000);
    rd(mmpu_pkg::OFS_COUNT, 32'h0000_0000);
    wr(8'h40, 32'hffff_ffff);
    rd(8'h40, 32'h0000_0000);
    for (int i = 0; i < 7; i++) begin
      seed = lfsr(seed);
      v = seed;
      wr(mmpu_pkg::OFS_MATCH0 + 8'(4 * i), v);
      rd(mmpu_pkg::OFS_MATCH0 + 8'(4 * i), v);
    end
    $display("test registers done");

    setup(0, 4, 2, 0, 32'h0000_0200);
    cmp_pin(32'(pwm_oe_o), 32'h0000_0001);
    count_hi(0, 50, 30);
    setup(1, 4, 2, 0, 32'h0000_0200);
    count_hi(0, 60, 36);
    setup(0, 4, 0, 0, 32'h0000_0200);
    count_hi(0, 50, 0);
    setup(0, 4, 1, 3, 32'h0000_0604);
    count_hi(1, 50, 20);
    setup(0, 4, 3, 1, 32'h0000_0604);
    count_hi(1, 50, 30);
    $display("test pulse shapes done");

    setup(0, 4, 2, 0, 32'h0000_0200);
    wr(mmpu_pkg::OFS_MATCH0 + 8'h04, 32'h0000_0001);
    count_hi(0, 50, 30);
    rd(mmpu_pkg::OFS_MATCH0 + 8'h04, 32'h0000_0001);
    wr(mmpu_pkg::OFS_RELEASE, 32'h0000_0002);
    repeat (10) @(posedge clk_i);
    count_hi(0, 50, 20);
    rd(mmpu_pkg::OFS_RELEASE, 32'h0000_0000);
    $display("test release done");

    wr(mmpu_pkg::OFS_ACTION, 32'h0000_0001);
    wr(mmpu_pkg::OFS_MASK, 32'h0000_0000);
    repeat (10) @(posedge clk_i);
    cmp_pin(32'(irq_o), 32'h0000_0000);
    wr(mmpu_pkg::OFS_MASK, 32'h0000_0001);
    @(negedge clk_i);
    cmp_pin(32'(irq_o), 32'h0000_0001);
    wr(mmpu_pkg::OFS_CTRL, 32'h0000_0000);
    wr(mmpu_pkg::OFS_STATUS, 32'h0000_007f);
    @(negedge clk_i);
    cmp_pin(32'(irq_o), 32'h0000_0000);
    $display("test interrupt done");

    setup(0, 4, 2, 0, 32'h0000_0200);
    wr(mmpu_pkg::OFS_ACTION, 32'h0000_0020);
    repeat (20) @(posedge clk_i);
    rd(mmpu_pkg::OFS_CTRL, 32'h0000_0008);
    wr(mmpu_pkg::OFS_CTRL, 32'h0000_0001);
    repeat (2) @(negedge clk_i);
    cmp_pin(32'({pwm_o, pwm_oe_o}), 32'h0000_0000);
    $display("test stop and timer mode done");
    give_verdict();
  end

endmodule : mmpu_top_tb

`default_nettype wire
